/* core/flash_option_protect_regs.sv */
// Flash option, configuration, security and protection register block
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
module flash_option_protect_regs
    import flash_opt_pkg::*;
#(
    parameter int PAGE_W = 7
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic [7:0]                  nonvolatileOptionByte,
    input  wire logic [7:0]                  nonvolatileProtectByte,
    input  wire logic [63:0]                 storedBackdoorKey,
    input  wire flash_opt_pkg::bus_req_t     busReq,
    input  wire logic                        busFromDebug,
    output logic [7:0]                       rdata,
    input  wire logic                        cmdStart,
    input  wire logic                        cmdMassErase,
    input  wire logic [PAGE_W-1:0]           cmdPage,
    output flash_opt_pkg::flash_cmd_t        cmdOut,
    input  wire logic                        memAccessReq,
    output logic                             memAccessGrant,
    output logic                             secure,
    output logic                             vectorRedirectDisable
);
    import flash_opt_pkg::*;

    logic [7:0]                 optionShadowReg;
    logic [7:0]                 configReg;
    logic [7:0]                 protectReg;
    logic                       violationFlag;
    logic                       forcedUnsecure;
    logic [KEY_BYTES*8-1:0]     keyCapture;
    logic [KEY_BYTES-1:0]       keyValid;
    logic                       keyMismatch;
    logic                       inKeyWindow;
    logic                       wrOption;
    logic                       wrProtect;
    logic                       wrStatus;
    logic                       keyWrite;
    logic                       protectDisable;
    logic                       boundaryGrows;
    logic                       pageProtected;
    logic                       anyProtected;
    logic                       violation;
    logic [1:0]                 securityCode;
    logic [7:0]                 next_protect;
    logic [2:0]                 keyIndex;
    logic [7:0]                 optionLoad;
    logic                       backdoorEnable;
    logic                       wrConfig;
    logic                       keySteer;
    logic                       steerClearing;
    logic                       keyComplete;
    logic [KEY_BYTES-1:0]       keyByteMatch;
    logic                       unlockRequest;
    logic                       unlockAllowed;
    logic [6:0]                 boundary;
    logic [6:0]                 newBoundary;
    logic [7:0]                 userProtect;
    logic [7:0]                 debugProtect;
    logic                       massRefused;
    logic                       pageRefused;
    logic                       clearViolation;
    logic                       cmdAccepted;
    logic [7:0]                 statusView;
    logic [7:0]                 next_rdata;

    // Address decode for the plain register port
    assign inKeyWindow = busReq.addr >= KEY_BASE && busReq.addr <= KEY_LAST;
    assign wrOption    = busReq.wrEn && busReq.addr == OFS_OPTION;
    assign wrConfig    = busReq.wrEn && busReq.addr == OFS_CONFIG;
    assign wrProtect   = busReq.wrEn && busReq.addr == OFS_PROTECT;
    assign wrStatus    = busReq.wrEn && busReq.addr == OFS_STATUS;
    assign keyIndex    = busReq.addr[2:0];

    // Steering decode; dropping the steer bit is also the compare trigger
    assign keySteer      = configReg[CFG_KEY_STEER];
    assign steerClearing = wrConfig && !busReq.wdata[CFG_KEY_STEER];

    // Option image as seen on the bus: unused bits forced low
    assign optionLoad = nonvolatileOptionByte & OPT_IMPL_MASK;

    // Option shadow: copied while reset is held, frozen until the next reset.
    // Loading during reset keeps security valid from the first cycle after it.
    always_ff @(posedge clk) begin
        if (srst) begin
            optionShadowReg <= optionLoad;
        end else if (wrOption) begin
            optionShadowReg <= optionShadowReg;
        end else begin
            optionShadowReg <= optionShadowReg;
        end
    end

    // Option fields used by the security logic
    assign backdoorEnable        = optionShadowReg[OPT_BACKDOOR];
    assign vectorRedirectDisable = optionShadowReg[OPT_NOREDIR];

    // Configuration: upper three bits writable at any time, the rest stay low
    always_ff @(posedge clk) begin
        if (srst) begin
            configReg <= ZERO8;
        end else if (wrConfig) begin
            configReg <= busReq.wdata & CFG_IMPL_MASK;
        end else begin
            configReg <= configReg;
        end
    end

    // Boundary fields of the current and the requested protection value
    assign boundary       = protectReg[7:1];
    assign newBoundary    = busReq.wdata[7:1];
    assign protectDisable = protectReg[PROT_DISABLE];

    // Lower boundary means a larger protected upper region
    assign boundaryGrows  = newBoundary < boundary;

    // Candidate values; the disable bit itself is only writable while set
    assign userProtect  = {newBoundary, protectReg[PROT_DISABLE]};
    assign debugProtect = {newBoundary, protectReg[PROT_DISABLE]};

    // Protection write filter: while the disable bit is clear, user writes may only grow the protected region
    always_comb begin
        next_protect = protectReg;
        if (wrProtect) begin
            if (protectDisable) begin
                next_protect = busReq.wdata;
            end else if (busFromDebug) begin
                next_protect = debugProtect;
            end else if (boundaryGrows) begin
                next_protect = userProtect;
            end else begin
                next_protect = protectReg;
            end
        end
    end

    // Protection register; the load holds during reset so it is valid at release
    always_ff @(posedge clk) begin
        if (srst) begin
            protectReg <= nonvolatileProtectByte;
        end else begin
            protectReg <= next_protect;
        end
    end

    // Key bytes from non-debug firmware writes only, secure or not, while steering selects key writes.
    // Debug writes never reach the slots, so a host cannot plant a key.
    assign keyWrite = busReq.wrEn && inKeyWindow && keySteer
                      && !busFromDebug;

    // Per-byte key slots; each slot owns one address of the key window
    generate
        for (genvar g = 0; g < KEY_BYTES; g++) begin : g_key_slot
            always_ff @(posedge clk) begin
                if (srst) begin
                    keyValid[g]          <= 1'b0;
                    keyCapture[g*8 +: 8] <= ZERO8;
                end else if (keyWrite && keyIndex == 3'(g)) begin
                    keyValid[g]          <= 1'b1;
                    keyCapture[g*8 +: 8] <= busReq.wdata;
                end else if (steerClearing) begin
                    keyValid[g]          <= 1'b0;
                end
            end

            // Slot compare against the stored key byte of the same position
            assign keyByteMatch[g] = keyCapture[g*8 +: 8] == storedBackdoorKey[g*8 +: 8];
        end
    endgenerate

    // Whole key present and equal in address order
    assign keyComplete   = &keyValid;
    assign keyMismatch   = !(&keyByteMatch);
    assign unlockRequest = steerClearing && keySteer && keyComplete && !keyMismatch;
    assign unlockAllowed = unlockRequest && backdoorEnable;

    // Successful compare unsecures only while the backdoor option bit is set; sticky until the next reset
    always_ff @(posedge clk) begin
        if (srst) begin
            forcedUnsecure <= 1'b0;
        end else if (unlockAllowed) begin
            forcedUnsecure <= 1'b1;
        end else begin
            forcedUnsecure <= forcedUnsecure;
        end
    end

    // Effective security code; a key match overrides the loaded code
    assign securityCode = forcedUnsecure ? SEC_UNSECURED : optionShadowReg[1:0];

    // Only one code pattern (10) is open, but a single flipped bit from 00 or 11 still reaches it and unsecures
    assign secure       = securityCode != SEC_UNSECURED;

    // Memory gate for debug accesses while secure
    assign memAccessGrant = memAccessReq && !(secure && busFromDebug);

    // Protection check on commands; page above the boundary is protected
    assign pageProtected = !protectDisable && cmdPage > boundary;
    assign anyProtected  = !protectDisable;
    assign massRefused   = cmdMassErase && anyProtected;
    assign pageRefused   = !cmdMassErase && pageProtected;
    assign violation     = cmdStart && (massRefused || pageRefused);

    // A command passes when it is clean and the key window is not steered away
    assign cmdAccepted = cmdStart && !violation && !keySteer;

    // Command strobe toward the sequencer; violating commands are dropped
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdOut.valid <= 1'b0;
        end else begin
            cmdOut.valid <= cmdAccepted;
        end
    end

    // Command kind travels beside the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdOut.massErase <= 1'b0;
        end else begin
            cmdOut.massErase <= cmdMassErase;
        end
    end

    // Target page travels beside the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdOut.page <= '0;
        end else begin
            cmdOut.page <= cmdPage;
        end
    end

    // Write-one clear of the violation flag
    assign clearViolation = wrStatus && busReq.wdata[STAT_VIOL];

    // Violation flag: set wins over write-one clear so no event is lost
    always_ff @(posedge clk) begin
        if (srst) begin
            violationFlag <= 1'b0;
        end else if (violation) begin
            violationFlag <= 1'b1;
        end else if (clearViolation) begin
            violationFlag <= 1'b0;
        end else begin
            violationFlag <= violationFlag;
        end
    end

    // Status view: only the violation flag lives in this block
    always_comb begin
        statusView            = ZERO8;
        statusView[STAT_VIOL] = violationFlag;
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = ZERO8;
        if (busReq.rdEn) begin
            case (busReq.addr)
                OFS_OPTION: begin
                    next_rdata = optionShadowReg;
                end
                OFS_CONFIG: begin
                    next_rdata = configReg;
                end
                OFS_PROTECT: begin
                    next_rdata = protectReg;
                end
                OFS_STATUS: begin
                    next_rdata = statusView;
                end
                default: begin
                    next_rdata = ZERO8;
                end
            endcase
        end
    end

    // Read data register: valid only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= ZERO8;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Unused inputs of this block are none; every port above is consumed.
    // Key slots clear when steering drops, so a half-written key never lingers
    // into the next attempt; the compare uses the slots before they clear.
    // The option shadow never follows the nonvolatile byte outside reset, so
    // reprogramming that byte has no effect until the next reset.
    // Debug writes to the protection boundary bypass the grow-only filter,
    // which lets a host unprotect every page, though a whole-array erase stays refused while the disable bit is clear.
    // The disable bit cannot be set by a user write once cleared; only a
    // reset with bit 0 of the nonvolatile byte set brings it back.
    // The violation flag and the command strobe are judged in one cycle,
    // so the sequencer never sees a command that raised the flag.
endmodule // flash_option_protect_regs

/* core/flash_opt_pkg.sv */
// Package with register map, field positions and types for the flash option block
package flash_opt_pkg;
    localparam int          ADDR_W          = 16;
    // Register offsets on the plain register port
    localparam logic [15:0] OFS_OPTION      = 16'h0000;
    localparam logic [15:0] OFS_CONFIG      = 16'h0001;
    localparam logic [15:0] OFS_PROTECT     = 16'h0002;
    localparam logic [15:0] OFS_STATUS      = 16'h0003;
    // Key window addresses
    localparam logic [15:0] KEY_BASE        = 16'hFFB0;
    localparam logic [15:0] KEY_LAST        = 16'hFFB7;
    localparam int          KEY_BYTES       = 8;
    // Option fields
    localparam int          OPT_BACKDOOR    = 7;
    localparam int          OPT_NOREDIR     = 6;
    localparam logic [7:0]  OPT_IMPL_MASK   = 8'hC3;
    localparam logic [1:0]  SEC_UNSECURED   = 2'h2;
    // Configuration fields
    localparam logic [7:0]  CFG_IMPL_MASK   = 8'hE0;
    localparam int          CFG_KEY_STEER   = 5;
    // Protection fields
    localparam int          PROT_DISABLE    = 0;
    // Status fields
    localparam int          STAT_VIOL       = 5;
    localparam logic [7:0]  ZERO8           = 8'h00;

    typedef struct packed {
        logic                   wrEn;
        logic                   rdEn;
        logic [ADDR_W-1:0]      addr;
        logic [7:0]             wdata;
    } bus_req_t;

    typedef struct packed {
        logic                   valid;
        logic                   massErase;
        logic [6:0]             page;
    } flash_cmd_t;
endpackage

/* verif/flash_opt_props.sv */
// Concurrent checks on the flash option block ports
`timescale 1ns/100ps
module flash_opt_props
    import flash_opt_pkg::*;
#(parameter int PAGE_W = 7) (
    input wire logic                     clk,
    input wire logic                     srst,
    input wire logic [7:0]               nonvolatileOptionByte,
    input wire flash_opt_pkg::bus_req_t  busReq,
    input wire logic                     busFromDebug,
    input wire logic [7:0]               rdata,
    input wire logic                     cmdStart,
    input wire logic [PAGE_W-1:0]        cmdPage,
    input wire flash_opt_pkg::flash_cmd_t cmdOut,
    input wire logic                     memAccessReq,
    input wire logic                     memAccessGrant,
    input wire logic                     secure,
    input wire logic                     vectorRedirectDisable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Option byte effects once the shadow has loaded
    AST_NOREDIR: assert property (!$past(srst) |->
        vectorRedirectDisable == nonvolatileOptionByte[OPT_NOREDIR]) else $error("bad redirect");
    AST_UNSEC_CODE: assert property (
        !$past(srst) && nonvolatileOptionByte[1:0] == SEC_UNSECURED |-> !secure)
        else $error("code 10 left secure");
    AST_NOKEY_SECURE: assert property (!$past(srst) && !nonvolatileOptionByte[OPT_BACKDOOR]
        && nonvolatileOptionByte[1:0] != SEC_UNSECURED |-> secure) else $error("unlocked w/o key");
    AST_GRANT: assert property (
        memAccessReq && busFromDebug && secure |-> !memAccessGrant) else $error("bad grant");
    AST_STAY_OPEN: assert property (!$past(srst) && !secure |=> !secure)
        else $error("relocked before reset");
    // Read data of the fixed fields, and the source of each command strobe
    AST_OPT_READ: assert property ($past(busReq.rdEn && busReq.addr == OFS_OPTION)
        && !$past(srst, 2) |-> rdata == (nonvolatileOptionByte & OPT_IMPL_MASK))
        else $error("bad option read");
    AST_CFG_READ: assert property ($past(busReq.rdEn && busReq.addr == OFS_CONFIG)
        |-> rdata[4:0] == 5'h00) else $error("config low bits set");
    AST_CMD_SRC: assert property (cmdOut.valid |-> $past(cmdStart)
        && cmdOut.page == $past(cmdPage)) else $error("command without start");
    COV_UNLOCK: cover property ($fell(secure));
    COV_CMD: cover property (cmdOut.valid);
    COV_DBG_BLOCK: cover property (memAccessReq && !memAccessGrant);
endmodule // flash_opt_props
bind flash_option_protect_regs flash_opt_props #(.PAGE_W(PAGE_W)) u_flash_opt_props (
    .clk(clk), .srst(srst), .nonvolatileOptionByte(nonvolatileOptionByte), .busReq(busReq),
    .busFromDebug(busFromDebug), .rdata(rdata), .cmdStart(cmdStart), .cmdPage(cmdPage),
    .cmdOut(cmdOut), .memAccessReq(memAccessReq), .memAccessGrant(memAccessGrant),
    .secure(secure), .vectorRedirectDisable(vectorRedirectDisable));

/* verif/nv_store_model.sv */
// Nonvolatile image model feeding the flash option block
`timescale 1ns/100ps
module nv_store_model (
    output logic [7:0]  optByte,
    output logic [7:0]  protByte,
    output logic [63:0] keyImg
);
    // Image as programmed; the bench reprograms it only while reset is held
    initial begin
        optByte  = 8'hFD;
        protByte = 8'h80;
        keyImg   = 64'h0123_4567_89AB_CDEF;
    end
endmodule // nv_store_model

/* verif/tb_top.sv */
// Self-checking bench for the flash option block
`timescale 1ns/100ps
module tb_top;
    import flash_opt_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, busFromDebug = 1'b0, cmdStart = 1'b0;
    logic        cmdMassErase = 1'b0, memAccessReq = 1'b0, secure, memAccessGrant, vrd;
    logic [6:0]  cmdPage = 7'h00;
    logic [7:0]  rdata, optByte, protByte;
    logic [63:0] keyImg;
    bus_req_t    busReq = '0;
    flash_cmd_t  cmdOut;
    int          err_count = 0, tests_run = 0;
    initial forever #5 clk = ~clk;
    nv_store_model u_nv_store_model (.optByte(optByte), .protByte(protByte), .keyImg(keyImg));
    flash_option_protect_regs u_flash_option_protect_regs (.clk(clk), .srst(srst),
        .nonvolatileOptionByte(optByte), .nonvolatileProtectByte(protByte),
        .storedBackdoorKey(keyImg), .busReq(busReq), .busFromDebug(busFromDebug), .rdata(rdata),
        .cmdStart(cmdStart), .cmdMassErase(cmdMassErase), .cmdPage(cmdPage), .cmdOut(cmdOut),
        .memAccessReq(memAccessReq), .memAccessGrant(memAccessGrant), .secure(secure),
        .vectorRedirectDisable(vrd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    // Reset for 12 cycles with a freshly programmed image
    task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot);
        srst <= 1'b1;
        u_nv_store_model.optByte <= opt;
        u_nv_store_model.protByte <= prot;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk);
        busReq <= '{1'b1, 1'b0, a, d};
        busFromDebug <= dbg;
        @(posedge clk);
        busReq <= '0;
        busFromDebug <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
        @(posedge clk);
        busReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        busReq <= '0;
        #1 chk(rdata & m, exp);
    endtask
    task automatic cmd(input logic mass, input logic [6:0] pg, input logic expv);
        @(posedge clk);
        cmdStart <= 1'b1;
        cmdMassErase <= mass;
        cmdPage <= pg;
        @(posedge clk);
        cmdStart <= 1'b0;
        #1 chk({7'h00, cmdOut.valid}, {7'h00, expv});
        if (expv) begin
            chk({7'h00, cmdOut.massErase}, {7'h00, mass});
            chk({1'b0, cmdOut.page}, {1'b0, pg});
        end
    endtask
    // Debug memory request; result packs secure and grant
    task automatic probe(input logic [7:0] exp);
        @(posedge clk);
        memAccessReq <= 1'b1;
        busFromDebug <= 1'b1;
        #1 chk({6'h00, secure, memAccessGrant}, exp);
        @(posedge clk);
        memAccessReq <= 1'b0;
        busFromDebug <= 1'b0;
    endtask
    task automatic send_key(input logic dbg);
        wr(OFS_CONFIG, 8'h20, 1'b0);
        for (int k = 0; k < KEY_BYTES; k++) wr(KEY_BASE + 16'(k), keyImg[8*k +: 8], dbg);
        wr(OFS_CONFIG, 8'h00, 1'b0);
        @(posedge clk);
    endtask
    task automatic t_option_unlock;
        do_reset(8'hFD, 8'h80);
        rd(OFS_OPTION, 8'hC1);
        wr(OFS_OPTION, 8'h02, 1'b0);
        rd(OFS_OPTION, 8'hC1);
        chk({7'h00, vrd}, 8'h01);
        wr(OFS_CONFIG, 8'hFF, 1'b0);
        rd(OFS_CONFIG, 8'hE0);
        send_key(1'b1);
        probe(8'h02);
        send_key(1'b0);
        probe(8'h01);
        do_reset(8'h41, 8'h80);
        chk({7'h00, vrd}, 8'h01);
        send_key(1'b0);
        probe(8'h02);
    endtask
    task automatic t_protect;
        rd(OFS_PROTECT, 8'h80);
        wr(OFS_PROTECT, 8'hA0, 1'b0);
        rd(OFS_PROTECT, 8'h80);
        wr(OFS_PROTECT, 8'h60, 1'b0);
        rd(OFS_PROTECT, 8'h60);
        cmd(1'b0, 7'h31, 1'b0);
        rd(OFS_STATUS, 8'h20, 8'h20);
        cmd(1'b0, 7'h30, 1'b1);
        cmd(1'b1, 7'h00, 1'b0);
        wr(OFS_STATUS, 8'h20, 1'b0);
        rd(OFS_STATUS, 8'h00, 8'h20);
        wr(OFS_PROTECT, 8'hE0, 1'b1);
        rd(OFS_PROTECT, 8'hE0);
        wr(OFS_CONFIG, 8'h20, 1'b0);
        cmd(1'b0, 7'h00, 1'b0);
        do_reset(8'h82, 8'h01);
        chk({7'h00, vrd}, 8'h00);
        cmd(1'b1, 7'h7F, 1'b1);
        cmd(1'b0, 7'h7F, 1'b1);
        rd(OFS_STATUS, 8'h00, 8'h20);
        wr(OFS_PROTECT, 8'hFE, 1'b0);
        rd(OFS_PROTECT, 8'hFE);
        probe(8'h01);
    endtask
    task automatic tally_and_finish;
        $display("Checks run: %0d, mismatches: %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        t_option_unlock();
        t_protect();
        tally_and_finish();
    end
    // Watchdog well beyond the fewer than two hundred cycles the scenarios need
    initial begin
        #50000;
        err_count++;
        tally_and_finish();
    end
endmodule // tb_top
